// [include/timer_one_pkg.sv]
// package: register map, field positions and constants of timer one
// ****************************************************************
// Behaviour
// R1: run bit 7 stops or starts counting
// R2: 8-bit counter steps once per input tick
// R3: wrap to zero sets sticky overflow flag
// R4: enabled overflow requests interrupt vector 8
// R5: reload written while running applies at overflow
// R6: reload bit governs reload unless pulse mode
// R7: keeps running in low power, never wakes
// R8: bit 3 picks internal or external clock
// R9: instruction clock prescale 256 down to 2
// R10: oscillator clock prescale 128 down to 1
// R11: fast-source bit picks oscillator over instruction
// R12: event mode ignores prescale and fast source
// R13: event mode blocks pin interrupt flag
// R14: pulse enable routes waveform to shared pin
// R15: half-rate toggle at overflow without pulse mode
// R16: software configures before setting run bit
// R17: pulse mode boundary 256, 64, 32, 16
// R18: event mode counts pin falling edges
// R19: disabling half-rate returns pin to GPIO
// R20: pulse high each cycle, low at match
// ****************************************************************
package timer_one_pkg;
   localparam logic [7:0] src_select_off = 8'hd8;
   localparam logic [7:0] mode_control_off = 8'hdc;
   localparam logic [7:0] count_off = 8'hdd;
   localparam logic [7:0] reload_off = 8'hde;
   localparam logic [7:0] control_off = 8'he0;
   localparam logic [7:0] status_off = 8'he4;
   localparam logic [7:0] mode_reset = 8'h00;
   localparam logic [7:0] src_reset = 8'h00;
   localparam int run_bit = 7;
   localparam int rate_lsb = 4;
   localparam int ext_bit = 3;
   localparam int reload_bit = 2;
   localparam int half_bit = 1;
   localparam int pulse_bit = 0;
   localparam int fast_bit = 3;
   localparam int other_fast_bit = 2;
   localparam int other_green_bit = 1;
   localparam int irq_en_bit = 0;
   localparam logic [7:0] irq_vector = 8'h08;
   localparam logic [1:0] resp_okay = 2'b00;
   localparam logic [1:0] resp_slverr = 2'b10;
   typedef enum logic [2:0] {
      st_idle = 3'b001,
      st_wait = 3'b010,
      st_resp = 3'b100
   } bus_state_e;
endpackage

// [logic/prescaler.sv]
// prescaler: turns the selected rate code into a one-cycle tick
`timescale 1ns/1ps
module prescaler
   import timer_one_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic enable,
   input wire logic fcpu_tick,
   input wire logic fhosc_tick,
   input wire logic fast_sel,
   input wire logic [2:0] rate,
   output logic tick
);
   logic [7:0] div_q;
   logic [7:0] div_d;
   logic src_tick;
   logic [7:0] mask;
   logic wrap;

   // R11 instruction clock or oscillator clock
   assign src_tick = fast_sel ? fhosc_tick : fcpu_tick;
   // R9 R10 code 000 divides by 256 or 128, 111 by 2 or 1
   assign mask = fast_sel ? (8'h7f >> rate) : (8'hff >> rate);
   assign wrap = (div_q & mask) == mask;
   assign tick = enable && src_tick && wrap;
   assign div_d = div_q + 8'h01;

   // free divider, held clear while stopped so the first period is whole
   always_ff @(posedge aclk) begin
      if (!aresetn || !enable) begin
         div_q <= 8'h00;
      end else if (src_tick) begin
         div_q <= wrap ? 8'h00 : div_d;
      end
   end
endmodule

// [logic/edge_catcher.sv]
// edge_catcher: falling edge detector for the event input pin
`timescale 1ns/1ps
module edge_catcher (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic pin,
   output logic fall
);
   logic last_q;

   // input taken as synchronous; one stage of history is enough
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_q <= 1'b1;
      end else begin
         last_q <= pin;
      end
   end
   assign fall = last_q && !pin; // R18
endmodule

// [logic/timer_one.sv]
// timer_one: 8-bit timer/counter with pulse and half-rate outputs
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
module timer_one
   import timer_one_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [9:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [9:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic fcpu_tick,
   input wire logic fhosc_tick,
   input wire logic green_mode,
   input wire logic event_input_pin,
   input wire logic pin_event,
   output logic pin_irq_flag,
   output logic external_irq_line,
   output logic irq_request,
   output logic [7:0] irq_vector_out,
   output logic wake_request,
   output logic shared_pin_sel,
   output logic shared_output_pin
);
   // ****************************************************************
   // register state
   // ****************************************************************
   // the source nibble holds bits 3:1 in place; bit 0 reads zero
   logic [7:0] mode_q;
   logic [3:0] src_q;
   logic [7:0] count_q;
   logic [7:0] count_d;
   // first reload copy takes writes, second feeds the compare
   logic [7:0] reload_buf_q;
   logic [7:0] reload_q;
   logic irq_en_q;
   logic overflow_flag_q;
   logic pin_flag_q;
   logic half_q;
   logic pulse_q;

   // ****************************************************************
   // mode decode
   // ****************************************************************
   logic counter_run_bit;
   logic external_source_select;
   logic reload_enable_bit;
   logic half_rate_output_enable;
   logic pulse_output_enable;
   logic [2:0] prescale_select;
   logic fast_source_select;
   // named slices so the logic reads like the map
   assign counter_run_bit = mode_q[run_bit];
   assign external_source_select = mode_q[ext_bit];
   assign reload_enable_bit = mode_q[reload_bit];
   assign half_rate_output_enable = mode_q[half_bit];
   assign pulse_output_enable = mode_q[pulse_bit];
   assign prescale_select = mode_q[rate_lsb+2:rate_lsb];
   assign fast_source_select = src_q[fast_bit];

   // ****************************************************************
   // count clock
   // ****************************************************************
   logic int_tick;
   logic ext_fall;
   logic step;

   // R16 settings are read live; mid-run changes are unsupported
   // the divider restarts whenever counting stops
   prescaler u_pre (
      .aclk(aclk),
      .aresetn(aresetn),
      .enable(counter_run_bit && !external_source_select),
      .fcpu_tick(fcpu_tick),
      .fhosc_tick(fhosc_tick),
      .fast_sel(fast_source_select),
      .rate(prescale_select),
      .tick(int_tick)
   );
   // a noisy pin needs its filter upstream
   edge_catcher u_edge (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(event_input_pin),
      .fall(ext_fall)
   );
   // R8 R12 event mode bypasses prescaler; R1 run bit gates all
   // R7 green mode does not gate the count
   assign step = counter_run_bit &&
      (external_source_select ? ext_fall : int_tick);

   // ****************************************************************
   // overflow boundary and reload
   // ****************************************************************
   logic [7:0] bmask;
   logic overflow;
   logic do_reload;
   // R17 pulse mode window 256, 64, 32 or 16 counts
   // outside pulse mode the full range is used
   assign bmask = !pulse_output_enable ? 8'hff :
      ({reload_enable_bit, half_rate_output_enable} == 2'b00) ? 8'hff :
      ({reload_enable_bit, half_rate_output_enable} == 2'b01) ? 8'h3f :
      ({reload_enable_bit, half_rate_output_enable} == 2'b10) ? 8'h1f :
      8'h0f;
   // only bits inside the window take part in the wrap
   assign overflow = step && ((count_q & bmask) == bmask); // R3
   // R6 pulse mode always reloads, else the reload bit decides
   assign do_reload = pulse_output_enable || reload_enable_bit;
   assign count_d = count_q + 8'h01; // R2

   // ****************************************************************
   // AXI4-Lite slave
   // ****************************************************************
   bus_state_e wst_q;
   logic aw_held_q;
   logic w_held_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic wr_fire;
   logic wr_lane0;
   logic wr_mode;
   logic wr_src;
   logic wr_count;
   logic wr_reload;
   logic wr_ctrl;
   logic wr_status;
   logic wr_hit;
   logic [31:0] rd_word;
   logic [7:0] rd_idx;
   logic rd_hit;

   // both readies stay low until the answer is taken,
   // so the held address and data stay safe to decode
   assign s_axi_awready = (wst_q == st_idle) && !aw_held_q;
   assign s_axi_wready = (wst_q == st_idle) && !w_held_q;
   assign s_axi_bvalid = (wst_q == st_resp);
   // decode on the captured word index
   assign wr_fire = (wst_q == st_wait);
   assign wr_lane0 = wr_fire && wstrb_q[0];
   assign wr_mode = wr_lane0 && (awaddr_q == mode_control_off);
   assign wr_src = wr_lane0 && (awaddr_q == src_select_off);
   assign wr_count = wr_lane0 && (awaddr_q == count_off);
   assign wr_reload = wr_lane0 && (awaddr_q == reload_off);
   assign wr_ctrl = wr_lane0 && (awaddr_q == control_off);
   assign wr_status = wr_lane0 && (awaddr_q == status_off);
   assign wr_hit = (awaddr_q == mode_control_off) ||
      (awaddr_q == src_select_off) || (awaddr_q == count_off) ||
      (awaddr_q == reload_off) || (awaddr_q == control_off) ||
      (awaddr_q == status_off);

   // write channel: collect address and data in any order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wst_q <= st_idle;
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
         s_axi_bresp <= resp_okay;
      end else begin
         case (wst_q)
            st_idle: begin
               if (s_axi_awvalid && !aw_held_q) begin
                  aw_held_q <= 1'b1;
                  awaddr_q <= s_axi_awaddr[9:2];
               end
               if (s_axi_wvalid && !w_held_q) begin
                  w_held_q <= 1'b1;
                  wdata_q <= s_axi_wdata;
                  wstrb_q <= s_axi_wstrb;
               end
               if ((aw_held_q || s_axi_awvalid) &&
                   (w_held_q || s_axi_wvalid)) begin
                  wst_q <= st_wait;
               end
            end
            // registers take the write at this edge
            st_wait: begin
               s_axi_bresp <= wr_hit ? resp_okay : resp_slverr;
               wst_q <= st_resp;
            end
            st_resp: begin
               if (s_axi_bready) begin
                  aw_held_q <= 1'b0;
                  w_held_q <= 1'b0;
                  wst_q <= st_idle;
               end
            end
            default: wst_q <= st_idle;
         endcase
      end
   end

   // read mux on the word index; reload is write-only and reads zero
   assign rd_idx = s_axi_araddr[9:2];
   assign rd_hit = (rd_idx == mode_control_off) ||
      (rd_idx == src_select_off) || (rd_idx == count_off) ||
      (rd_idx == reload_off) || (rd_idx == control_off) ||
      (rd_idx == status_off);
   assign rd_word =
      (rd_idx == mode_control_off) ? {24'h0, mode_q} :
      (rd_idx == src_select_off) ? {28'h0, src_q} :
      (rd_idx == count_off) ? {24'h0, count_q} :
      (rd_idx == control_off) ? {31'h0, irq_en_q} :
      (rd_idx == status_off) ? {30'h0, pin_flag_q, overflow_flag_q} :
      32'h0;
   // no new address while read data waits to be taken
   assign s_axi_arready = !s_axi_rvalid;

   // read answer one cycle after the address is taken
   // rdata loads only on a new address, so it holds
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= resp_okay;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_hit ? resp_okay : resp_slverr;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****************************************************************
   // configuration registers
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_q <= mode_reset;
         src_q <= src_reset[3:0];
         irq_en_q <= 1'b0;
      end else begin
         if (wr_mode) begin
            mode_q <= wdata_q[7:0];
         end
         // unused source bits are dropped
         if (wr_src) begin
            src_q <= {4'h0 | {wdata_q[fast_bit], wdata_q[other_fast_bit],
               wdata_q[other_green_bit], 1'b0}};
         end
         if (wr_ctrl) begin
            irq_en_q <= wdata_q[irq_en_bit];
         end
      end
   end

   // ****************************************************************
   // counter and double-buffered reload
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_q <= 8'h00;
         reload_buf_q <= 8'h00;
         reload_q <= 8'h00;
      end else begin
         if (wr_reload) begin
            reload_buf_q <= wdata_q[7:0]; // R5
         end
         // a wrap outranks a count write in one cycle
         if (overflow) begin
            // R5 buffered value becomes live at overflow
            reload_q <= reload_buf_q;
            count_q <= do_reload ? reload_buf_q : 8'h00; // R6
         end else if (wr_count) begin
            count_q <= wdata_q[7:0];
         end else if (step) begin
            count_q <= count_d; // R2
         end
         // before the first run both copies follow software
         // a running counter keeps its copy until the wrap
         if (wr_reload && !counter_run_bit) begin
            reload_q <= wdata_q[7:0];
         end
      end
   end

   // ****************************************************************
   // flags: hardware set wins over software clear
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         overflow_flag_q <= 1'b0;
         pin_flag_q <= 1'b0;
      end else begin
         if (overflow) begin
            overflow_flag_q <= 1'b1; // R3
         end else if (wr_status && !wdata_q[0]) begin
            overflow_flag_q <= 1'b0; // R3
         end
         // forced low in event mode so no pin request leaks
         if (external_source_select) begin
            pin_flag_q <= 1'b0; // R13
         end else if (pin_event) begin
            pin_flag_q <= 1'b1;
         end else if (wr_status && !wdata_q[1]) begin
            pin_flag_q <= 1'b0;
         end
      end
   end
   // requests are plain gates of the registered flags
   assign pin_irq_flag = pin_flag_q;
   assign external_irq_line = pin_flag_q && !external_source_select; // R13
   assign irq_request = overflow_flag_q && irq_en_q; // R4
   assign irq_vector_out = irq_request ? irq_vector : 8'h00; // R4
   // R7 never wakes the system from green mode
   assign wake_request = irq_request && !green_mode;

   // ****************************************************************
   // pulse and half-rate outputs
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         half_q <= 1'b0;
         pulse_q <= 1'b1;
      end else begin
         if (overflow) begin
            half_q <= !half_q; // R15
            pulse_q <= 1'b1; // R20
         end else if (step && ((count_d & bmask) == (reload_q & bmask))) begin
            pulse_q <= 1'b0; // R20
         end
      end
   end
   // the pin returns to gpio once both enables clear
   // R14 pulse first; R15 R19 half rate only without pulse, else GPIO
   assign shared_pin_sel = pulse_output_enable || half_rate_output_enable;
   assign shared_output_pin = pulse_output_enable ? pulse_q :
      half_rate_output_enable ? half_q : 1'b0;
endmodule

// [bench/timer_one_assertions.sv]
// checker: port-level properties of timer_one
`timescale 1ns/1ps
module timer_one_assertions (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic green_mode,
   input wire logic pin_irq_flag,
   input wire logic external_irq_line,
   input wire logic irq_request,
   input wire logic [7:0] irq_vector_out,
   input wire logic wake_request,
   input wire logic shared_pin_sel,
   input wire logic shared_output_pin
);
   // ****************************************************************
   // properties, one clock domain
   // ****************************************************************
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_IRQ_VECTOR: assert property (irq_request |-> irq_vector_out == 8'h08)
      else $error("vector wrong while request");
   AST_NO_VECTOR: assert property (!irq_request |-> irq_vector_out == 8'h00)
      else $error("vector shown without request");
   AST_GREEN_NO_WAKE: assert property (green_mode |-> !wake_request)
      else $error("wake raised in green mode");
   AST_WAKE: assert property (irq_request && !green_mode |-> wake_request)
      else $error("wake missing for request");
   AST_PIN_GPIO: assert property (!shared_pin_sel |-> !shared_output_pin)
      else $error("pin driven while left to gpio");
   AST_EXT_LINE: assert property (external_irq_line |-> pin_irq_flag)
      else $error("pin line without pin flag");
   // flag may only fall after a register write
   AST_FLAG_STICKY: assert property (irq_request && !s_axi_wvalid &&
      !$past(s_axi_wvalid) |=> irq_request)
      else $error("overflow request dropped without write");
   AST_B_LATENCY: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##[2:3] s_axi_bvalid)
      else $error("write response late");
   AST_R_LATENCY: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid)
      else $error("read data late");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
endmodule
bind timer_one timer_one_assertions i_chk (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
   .s_axi_rdata, .green_mode, .pin_irq_flag, .external_irq_line,
   .irq_request, .irq_vector_out, .wake_request, .shared_pin_sel,
   .shared_output_pin);

// [bench/pulse_source.sv]
// partner: clock ticks and falling-edge train on the event pin
`timescale 1ns/1ps
module pulse_source (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic start,
   input wire logic [8:0] edges,
   output logic fcpu_tick,
   output logic fhosc_tick,
   output logic event_input_pin,
   output logic busy
);
   logic [1:0] phase_q;
   logic [8:0] left_q;
   // oscillator tick every 2nd cycle, instruction tick every 4th
   assign fhosc_tick = phase_q[0];
   assign fcpu_tick = &phase_q;
   assign busy = left_q != 9'h000;
   // pin idles high like a pulled-up input; one fall per 4 cycles
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_q <= 2'h0;
         left_q <= 9'h000;
         event_input_pin <= 1'b1;
      end else begin
         phase_q <= phase_q + 2'h1;
         if (start) begin
            left_q <= edges;
         end else if (busy && phase_q == 2'h1) begin
            event_input_pin <= 1'b0;
            left_q <= left_q - 9'h001;
         end else if (phase_q == 2'h3) begin
            event_input_pin <= 1'b1;
         end
      end
   end
endmodule

// [bench/timer_one_test.sv]
// testbench: register, timing and output checks of timer_one
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin \
   error_cnt++; $display("BAD %s exp %0h got %0h", n, e, s); end end
module timer_one_test
   import timer_one_pkg::*;
;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, fcpu_tick;
   logic fhosc_tick, green_mode, event_input_pin, pin_event;
   logic pin_irq_flag, external_irq_line, irq_request, wake_request;
   logic shared_pin_sel, shared_output_pin, start, busy, pin_at;
   logic pin_first;
   logic [9:0] s_axi_awaddr, s_axi_araddr;
   logic [7:0] irq_vector_out;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic [8:0] edges;
   int error_cnt, checks_done, cyc, d;
   int nb[4] = '{256, 64, 32, 16};
   timer_one i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fcpu_tick, .fhosc_tick,
      .green_mode, .event_input_pin, .pin_event, .pin_irq_flag,
      .external_irq_line, .irq_request, .irq_vector_out, .wake_request,
      .shared_pin_sel, .shared_output_pin);
   pulse_source i_src (.aclk, .aresetn, .start, .edges, .fcpu_tick,
      .fhosc_tick, .event_input_pin, .busy);
   // ****************************************************************
   // clock, watchdog and closing
   // ****************************************************************
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // ceiling well above the longest measured period sum
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("mismatches %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ****************************************************************
   // bus and helper tasks
   // ****************************************************************
   task automatic axw(input logic [7:0] a, input logic [7:0] v,
      input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= {a, 2'b00};
      s_axi_wdata <= {24'h000000, v};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!(s_axi_bvalid && s_axi_bready));
      s_axi_bready <= 1'b0;
      `CHK("bresp", er, s_axi_bresp)
   endtask
   // tasks take the word index; the byte address is four times that
   task automatic axr(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= {a, 2'b00};
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!(s_axi_rvalid && s_axi_rready));
      s_axi_rready <= 1'b0;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
   endtask
   task automatic wait_irq(output int t);
      t = -1;
      for (int k = 0; k < 20000 && t < 0; k++) begin
         @(posedge aclk);
         if (irq_request === 1'b1) t = cyc;
      end
      pin_at = shared_output_pin;
   endtask
   // spacing of two overflows, independent of the start count
   task automatic period(input logic [7:0] src, input logic [7:0] mode,
      output int dt);
      int t1, t2;
      axw(src_select_off, src, resp_okay);
      axw(mode_control_off, mode, resp_okay);
      wait_irq(t1);
      pin_first = pin_at;
      axw(status_off, 8'h00, resp_okay);
      wait_irq(t2);
      dt = t2 - t1;
   endtask
   task automatic halt();
      axw(mode_control_off, 8'h00, resp_okay);
      axw(status_off, 8'h00, resp_okay);
   endtask
   task automatic pin_evt();
      @(posedge aclk);
      pin_event <= 1'b1;
      @(posedge aclk);
      pin_event <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask
   task automatic burst(input logic [8:0] n);
      @(posedge aclk);
      start <= 1'b1;
      edges <= n;
      @(posedge aclk);
      start <= 1'b0;
      repeat (2) @(posedge aclk);
      while (busy !== 1'b0) @(posedge aclk);
      repeat (8) @(posedge aclk);
   endtask
   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_regs();
      axr(mode_control_off);
      `CHK("mode reset", 32'h0, rd)
      axr(src_select_off);
      `CHK("src reset", 32'h0, rd)
      axw(src_select_off, 8'hff, resp_okay);
      axr(src_select_off);
      `CHK("src bits", 32'he, rd)
      axr(8'hf0);
      axw(8'hf0, 8'h01, resp_slverr);
      `CHK("unmapped read", resp_slverr, rr)
      axw(control_off, 8'h01, resp_okay);
   endtask
   // internal ticks keep running and must not be counted
   task automatic t_event();
      axw(mode_control_off, 8'hf8, resp_okay);
      pin_evt();
      `CHK("pin flag event", 1'b0, pin_irq_flag)
      burst(9'd255);
      `CHK("early overflow", 1'b0, irq_request)
      burst(9'd1);
      `CHK("event overflow", 1'b1, irq_request)
      `CHK("vector", irq_vector, irq_vector_out)
      halt();
      pin_evt();
      `CHK("pin flag gpio", 1'b1, pin_irq_flag)
      axw(status_off, 8'h00, resp_okay);
      axw(mode_control_off, 8'h70, resp_okay);
      repeat (600) @(posedge aclk);
      `CHK("stopped", 1'b0, irq_request)
   endtask
   task automatic t_rates();
      logic [2:0] r;
      for (int c = 4; c < 8; c++) begin
         r = c[2:0];
         if (c == 7) green_mode <= 1'b1;
         period(8'h08, {1'b1, r, 4'h0}, d);
         `CHK("fast rate", (128 >> c) * 512, d)
         if (c == 7) begin
            `CHK("green wake", 1'b0, wake_request)
            @(posedge aclk);
            green_mode <= 1'b0;
            repeat (2) @(posedge aclk);
            `CHK("wake", 1'b1, wake_request)
         end
         halt();
      end
      for (int c = 6; c < 8; c++) begin
         r = c[2:0];
         period(8'h00, {1'b1, r, 4'h0}, d);
         `CHK("cpu rate", (256 >> c) * 1024, d)
         halt();
      end
   endtask
   task automatic t_outputs();
      for (int b = 0; b < 4; b++) begin
         period(8'h08, 8'hf1 | 8'(b << 1), d);
         `CHK("pulse span", nb[b] * 2, d)
         `CHK("pulse sel", 1'b1, shared_pin_sel)
         halt();
      end
      period(8'h08, 8'hf2, d);
      `CHK("half span", 512, d)
      `CHK("half toggle", ~pin_first, pin_at)
      axw(mode_control_off, 8'hf0, resp_okay);
      `CHK("gpio back", 1'b0, shared_pin_sel)
      axw(status_off, 8'h00, resp_okay);
      wait_irq(d);
      `CHK("still counts", 1'b1, d > 0)
   endtask
   // reload sets the span; a new value waits for the wrap
   task automatic t_reload();
      int t3, t4;
      halt();
      axw(count_off, 8'h5a, resp_okay);
      axr(count_off);
      `CHK("count", 32'h5a, rd)
      axw(reload_off, 8'hc0, resp_okay);
      period(8'h08, 8'hf4, d);
      `CHK("reload span", 128, d)
      axw(reload_off, 8'h80, resp_okay);
      axw(status_off, 8'h00, resp_okay);
      wait_irq(t3);
      axw(status_off, 8'h00, resp_okay);
      wait_irq(t4);
      `CHK("new span", 256, t4 - t3)
   endtask
   initial begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
      {s_axi_rready, green_mode, pin_event, start} = 4'h0;
      {s_axi_awaddr, s_axi_araddr, edges} = 29'h0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      error_cnt = 0;
      checks_done = 0;
      cyc = 0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_event();
      t_rates();
      t_outputs();
      t_reload();
      report_and_stop();
   end
endmodule
